// *** pkg/aft_pkg.sv ***
// constants, types and field layout for the front end control block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`default_nettype none
package aft_pkg;
  // ---------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 200_000_000;
  localparam int TIMER_FREQ_HZ = 4_000_000;
  localparam int TICK_DIV      = CLK_FREQ_HZ / TIMER_FREQ_HZ;
  localparam int FAULT_FLAG_REGISTER_TIME_MS  = 16;
  localparam int FAULT_FLAG_REGISTER_CYCLES   = FAULT_FLAG_REGISTER_TIME_MS * (CLK_FREQ_HZ / 1000);
  // ---------------------------------------------------------------
  // serial frame and register map
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 24;
  localparam int COUNT_W = 16;
  localparam logic [4:0] ADDR_LAST_BIT  = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h1f;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE_START = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE_END   = 8'h02;
  // ---------------------------------------------------------------
  // main_control field positions and sample window count reset value
  // ---------------------------------------------------------------
  localparam int SOFT_RESET_BIT     = 3;
  localparam int SELFTEST_START_BIT = 2;
  localparam int TIMING_HOLD_BIT    = 1;
  localparam int READ_EN_BIT        = 0;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ADDR = 2'b00,
    ST_DATA = 2'b01,
    ST_DONE = 2'b11
  } aft_spi_st_t;
  typedef struct packed {
    logic [COUNT_W-1:0] start;
    logic [COUNT_W-1:0] stop;
  } aft_window_t;
  typedef struct packed {
    logic hold;
    logic read_en;
  } aft_ctrl_t;
endpackage
`default_nettype wire

// *** hdl/aft_timing.sv ***
// period counter, first-LED sample window and diagnostics timer
`timescale 1ns/1ps
`default_nettype none
module aft_timing #(
  parameter int TICK_DIV    = aft_pkg::TICK_DIV,
  parameter int FAULT_FLAG_REGISTER_CYCLES = aft_pkg::FAULT_FLAG_REGISTER_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       hold,
  input  wire aft_pkg::aft_window_t       win,
  input  wire logic [aft_pkg::COUNT_W-1:0] period_cnt,
  input  wire logic                       fault_flag_register_go,
  output var  logic                       sample,
  output var  logic                       fault_flag_register_busy,
  output var  logic                       fault_flag_register_done
);
  localparam int TW = $clog2(TICK_DIV);
  localparam int DW = (FAULT_FLAG_REGISTER_CYCLES > 1) ? $clog2(FAULT_FLAG_REGISTER_CYCLES) : 1;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (TICK_DIV < 2) begin : g_bad_div
    $error("tick divider must be at least two");
  end
  if (FAULT_FLAG_REGISTER_CYCLES < 1) begin : g_bad_fault_flag_register
    $error("diagnostics length must be at least one cycle");
  end

  logic [TW-1:0]               tick_cnt_r, tick_cnt_nxt;
  logic [aft_pkg::COUNT_W-1:0] prd_cnt_r, prd_cnt_nxt;
  logic [DW-1:0]               fault_flag_register_cnt_r, fault_flag_register_cnt_nxt;
  logic                        sample_r, sample_nxt;
  logic                        busy_r, busy_nxt;
  logic                        done_r, done_nxt;
  logic                        tick;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    tick         = (tick_cnt_r == TW'(TICK_DIV - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    prd_cnt_nxt  = prd_cnt_r;
    if (tick) begin
      // wrap at the programmed period length
      prd_cnt_nxt = (prd_cnt_r >= period_cnt) ? '0 : prd_cnt_r + 1'b1;
    end
    if (hold) begin
      tick_cnt_nxt = '0;
      prd_cnt_nxt  = '0;
    end
    // window compare, inclusive at both ends
    sample_nxt = !hold && (prd_cnt_r >= win.start) &&
                 (prd_cnt_r <= win.stop);
    fault_flag_register_cnt_nxt = fault_flag_register_cnt_r;
    busy_nxt     = busy_r;
    done_nxt     = 1'b0;
    if (busy_r) begin
      fault_flag_register_cnt_nxt = fault_flag_register_cnt_r + 1'b1;
      if (fault_flag_register_cnt_r == DW'(FAULT_FLAG_REGISTER_CYCLES - 1)) begin
        busy_nxt     = 1'b0;
        done_nxt     = 1'b1;
        fault_flag_register_cnt_nxt = '0;
      end
    end else if (fault_flag_register_go) begin
      busy_nxt     = 1'b1;
      fault_flag_register_cnt_nxt = '0;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_r <= '0;
      prd_cnt_r  <= '0;
      fault_flag_register_cnt_r <= '0;
      sample_r   <= 1'b0;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      prd_cnt_r  <= prd_cnt_nxt;
      fault_flag_register_cnt_r <= fault_flag_register_cnt_nxt;
      sample_r   <= sample_nxt;
      busy_r     <= busy_nxt;
      done_r     <= done_nxt;
    end
  end

  assign sample    = sample_r;
  assign fault_flag_register_busy = busy_r;
  assign fault_flag_register_done = done_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_hold_clears_count: assert property (@(posedge clk) disable iff (rst)
    hold |=> (prd_cnt_r == '0) && !sample_r)
    else $error("period count not held while hold is set");
  a_window_sample: assert property (@(posedge clk) disable iff (rst)
    (!hold && prd_cnt_r >= win.start && prd_cnt_r <= win.stop)
    |=> sample_r)
    else $error("sample low inside window");
  a_period_wraps: assert property (@(posedge clk) disable iff (rst)
    (!hold && tick && prd_cnt_r >= period_cnt) |=> (prd_cnt_r == '0))
    else $error("period counter did not wrap");
  a_tick_rate: assert property (@(posedge clk) disable iff (rst)
    (!hold && tick_cnt_r == '0) |=> (tick_cnt_r == TW'(1)))
    else $error("tick divider misbehaves");
  a_fault_flag_register_ends: assert property (@(posedge clk) disable iff (rst)
    (busy_r && fault_flag_register_cnt_r == DW'(FAULT_FLAG_REGISTER_CYCLES - 1)) |=> (!busy_r && done_r))
    else $error("diagnostics did not end on time");
  a_fault_flag_register_starts: assert property (@(posedge clk) disable iff (rst)
    (!busy_r && fault_flag_register_go) |=> (busy_r && fault_flag_register_cnt_r == '0))
    else $error("diagnostics did not start");
  c_fault_flag_register_done: cover property (@(posedge clk) disable iff (rst) done_r);
  c_sample_rise: cover property (@(posedge clk) disable iff (rst)
    $rose(sample_r));
endmodule
`default_nettype wire

// *** hdl/aft_control.sv ***
// serial register slave, control register and sample window registers
`timescale 1ns/1ps
`default_nettype none
module aft_control #(
  parameter int FAULT_FLAG_REGISTER_CYCLES = aft_pkg::FAULT_FLAG_REGISTER_CYCLES
) (
  input  wire logic                        CLK,
  input  wire logic                        RESET,
  input  wire logic                        SCLK,
  input  wire logic                        MOSI,
  input  wire logic                        CS_N,
  input  wire logic [aft_pkg::COUNT_W-1:0] PERIOD_COUNT,
  output var  logic                        MISO,
  output var  logic                        SAMPLE_LED1,
  output var  logic                        FAULT_FLAG_REGISTER_ACTIVE,
  output var  logic                        FAULT_FLAG_REGISTER_DONE,
  output var  logic                        TIMER_HOLD
);
  // ---------------------------------------------------------------
  // readback decode
  // ---------------------------------------------------------------
  function automatic logic [aft_pkg::DATA_W-1:0] read_word(
    input logic [aft_pkg::ADDR_W-1:0] a,
    input aft_pkg::aft_window_t       w
  );
    read_word = 24'h000000; // control and unmapped read as zero
    if (a == aft_pkg::ADDR_SAMPLE_START) begin
      read_word = {8'h00, w.start};
    end else if (a == aft_pkg::ADDR_SAMPLE_END) begin
      read_word = {8'h00, w.stop};
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync_s1_r;
  logic [2:0] sync_s2_r;
  logic       sclk_d_r;
  logic       sclk_s;
  logic       mosi_s;
  logic       cs_act;
  logic       sclk_rise;
  logic       sclk_fall;

  // two stages per pin, then an edge history on the clock only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sync_s1_r <= 3'h4; // idle pins: deselected, clock low
      sync_s2_r <= 3'h4; // no false clock edge after reset
      sclk_d_r  <= 1'b0;
    end else begin
      sync_s1_r <= {CS_N, SCLK, MOSI};
      sync_s2_r <= sync_s1_r;
      sclk_d_r  <= sync_s2_r[1];
    end
  end

  assign mosi_s    = sync_s2_r[0];
  assign sclk_s    = sync_s2_r[1];
  assign cs_act    = !sync_s2_r[2];
  assign sclk_rise = sclk_s && !sclk_d_r;
  assign sclk_fall = !sclk_s && sclk_d_r;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aft_pkg::aft_spi_st_t        st_r, st_nxt;
  logic [4:0]                  bit_cnt_r, bit_cnt_nxt;
  logic [aft_pkg::DATA_W-1:0]  shin_r, shin_nxt;
  logic [aft_pkg::DATA_W-1:0]  shout_r, shout_nxt;
  logic [aft_pkg::ADDR_W-1:0]  addr_r, addr_nxt;
  logic                        miso_r, miso_nxt;
  logic                        soft_r, soft_nxt;
  logic                        go_r, go_nxt;
  aft_pkg::aft_ctrl_t          ctrl_r, ctrl_nxt;
  aft_pkg::aft_window_t        win_r, win_nxt;
  logic [aft_pkg::DATA_W-1:0]  wdata;
  logic                        int_rst;
  logic                        fault_flag_register_busy;

  // soft reset clears everything except the serial engine itself
  assign int_rst = RESET || soft_r;
  assign wdata   = {shin_r[aft_pkg::DATA_W-2:0], mosi_s};

  // ---------------------------------------------------------------
  // serial frame and register write logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    bit_cnt_nxt = bit_cnt_r;
    shin_nxt    = shin_r;
    shout_nxt   = shout_r;
    addr_nxt    = addr_r;
    miso_nxt    = miso_r;
    soft_nxt    = 1'b0;
    go_nxt      = 1'b0;
    ctrl_nxt    = ctrl_r;
    win_nxt     = win_r;
    if (!cs_act) begin
      st_nxt      = aft_pkg::ST_ADDR;
      bit_cnt_nxt = '0;
      miso_nxt    = 1'b0;
    end else begin
      case (st_r)
        aft_pkg::ST_ADDR: begin
          if (sclk_rise) begin
            shin_nxt    = wdata;
            bit_cnt_nxt = bit_cnt_r + 1'b1;
            if (bit_cnt_r == aft_pkg::ADDR_LAST_BIT) begin
              addr_nxt  = wdata[aft_pkg::ADDR_W-1:0];
              st_nxt    = aft_pkg::ST_DATA;
              // readback only when enabled, control reads zero
              shout_nxt = ctrl_r.read_en ?
                          read_word(wdata[aft_pkg::ADDR_W-1:0], win_r) :
                          24'h000000;
            end
          end
        end
        aft_pkg::ST_DATA: begin
          if (sclk_fall) begin
            miso_nxt  = shout_r[aft_pkg::DATA_W-1];
            shout_nxt = {shout_r[aft_pkg::DATA_W-2:0], 1'b0};
          end
          if (sclk_rise) begin
            shin_nxt    = wdata;
            bit_cnt_nxt = bit_cnt_r + 1'b1;
            if (bit_cnt_r == aft_pkg::FRAME_LAST_BIT) begin
              st_nxt = aft_pkg::ST_DONE;
              if (addr_r == aft_pkg::ADDR_MAIN_CONTROL) begin
                // upper control bits are ignored; host keeps them zero
                soft_nxt         = wdata[aft_pkg::SOFT_RESET_BIT];
                go_nxt           = wdata[aft_pkg::SELFTEST_START_BIT];
                ctrl_nxt.hold    = wdata[aft_pkg::TIMING_HOLD_BIT];
                ctrl_nxt.read_en = wdata[aft_pkg::READ_EN_BIT];
              end else if (!ctrl_r.read_en) begin
                if (addr_r == aft_pkg::ADDR_SAMPLE_START) begin
                  win_nxt.start = wdata[aft_pkg::COUNT_W-1:0];
                end else if (addr_r == aft_pkg::ADDR_SAMPLE_END) begin
                  win_nxt.stop = wdata[aft_pkg::COUNT_W-1:0];
                end
              end
            end
          end
        end
        aft_pkg::ST_DONE: begin
          miso_nxt = 1'b0; // extra clocks after a frame are ignored
        end
        default: begin
          st_nxt = aft_pkg::ST_ADDR;
        end
      endcase
    end
  end

  // serial engine registers, cleared by the pin reset only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r      <= aft_pkg::ST_ADDR;
      bit_cnt_r <= '0;
      shin_r    <= '0;
      shout_r   <= '0;
      addr_r    <= '0;
      miso_r    <= 1'b0;
      soft_r    <= 1'b0;
      go_r      <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shin_r    <= shin_nxt;
      shout_r   <= shout_nxt;
      addr_r    <= addr_nxt;
      miso_r    <= miso_nxt;
      soft_r    <= soft_nxt;
      go_r      <= go_nxt;
    end
  end

  // register bank, cleared by pin reset or soft reset
  always_ff @(posedge CLK) begin
    if (int_rst) begin
      ctrl_r <= '0;
      win_r  <= '{start: aft_pkg::COUNT_RST, stop: aft_pkg::COUNT_RST};
    end else begin
      ctrl_r <= ctrl_nxt;
      win_r  <= win_nxt;
    end
  end

  // ---------------------------------------------------------------
  // timing engine
  // ---------------------------------------------------------------
  aft_timing #(
    .TICK_DIV    (aft_pkg::TICK_DIV),
    .FAULT_FLAG_REGISTER_CYCLES (FAULT_FLAG_REGISTER_CYCLES)
  ) u_timing (
    .clk        (CLK),
    .rst        (int_rst),
    .hold       (ctrl_r.hold),
    .win        (win_r),
    .period_cnt (PERIOD_COUNT),
    .fault_flag_register_go    (go_r),
    .sample     (SAMPLE_LED1),
    .fault_flag_register_busy  (fault_flag_register_busy),
    .fault_flag_register_done  (FAULT_FLAG_REGISTER_DONE)
  );

  assign MISO        = miso_r;
  assign FAULT_FLAG_REGISTER_ACTIVE = fault_flag_register_busy;
  assign TIMER_HOLD  = ctrl_r.hold;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ctrl_reads_zero: assert property (@(posedge CLK) disable iff (RESET)
    (st_r == aft_pkg::ST_DATA && addr_r == aft_pkg::ADDR_MAIN_CONTROL)
    |-> (shout_r == '0) && !miso_r)
    else $error("control register data seen on readback");
  a_read_gated: assert property (@(posedge CLK) disable iff (RESET)
    (cs_act && st_r == aft_pkg::ST_ADDR && sclk_rise &&
     bit_cnt_r == aft_pkg::ADDR_LAST_BIT && !ctrl_r.read_en)
    |=> (shout_r == '0))
    else $error("readback loaded while disabled");
  a_soft_clears: assert property (@(posedge CLK) disable iff (RESET)
    soft_r |=> (win_r == '0) && (ctrl_r == '0) && !FAULT_FLAG_REGISTER_ACTIVE && !soft_r)
    else $error("soft reset left state behind");
  a_end_written: assert property (@(posedge CLK) disable iff (int_rst)
    (cs_act && st_r == aft_pkg::ST_DATA && sclk_rise &&
     bit_cnt_r == aft_pkg::FRAME_LAST_BIT && !ctrl_r.read_en &&
     addr_r == aft_pkg::ADDR_SAMPLE_END)
    |=> (win_r.stop == $past(wdata[aft_pkg::COUNT_W-1:0])))
    else $error("sample end count not written");
  c_soft_reset: cover property (@(posedge CLK) disable iff (RESET) soft_r);
  c_read_frame: cover property (@(posedge CLK) disable iff (RESET)
    st_r == aft_pkg::ST_DATA && ctrl_r.read_en && miso_r);
  c_fault_flag_register_run: cover property (@(posedge CLK) disable iff (RESET)
    $rose(FAULT_FLAG_REGISTER_ACTIVE));
endmodule
`default_nettype wire

// *** tb/aft_spi_host.sv ***
// serial host model that drives register frames into the control block
`timescale 1ns/1ps
`default_nettype none
module aft_spi_host (
  input  wire logic clk,
  input  wire logic miso,
  output var  logic sclk,
  output var  logic mosi,
  output var  logic cs_n
);
  // idle bus: deselected, clock parked low
  initial begin
    sclk = 1'b0;
    mosi = 1'b1;
    cs_n = 1'b1;
  end
  // let n clock edges pass, then move just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one frame: 8 address bits then 24 data bits, read bits shifted in
  task automatic xfer(input  logic [7:0]  addr,
                      input  logic [23:0] wdata,
                      input  int          half,
                      output logic [23:0] rdata);
    logic [31:0] sh;
    sh = {addr, wdata};
    if (addr == aft_pkg::ADDR_MAIN_CONTROL) begin
      sh[23:4] = 20'h00000;
    end else begin
      sh[23:16] = 8'h00;
    end
    rdata = 24'h000000;
    step(1);
    cs_n = 1'b0;
    // mode 0: data moves after the fall, read bit taken at the rise
    for (int i = 0; i < 32; i++) begin
      mosi = sh[31-i];
      step(half);
      if (i >= 8) begin
        rdata = {rdata[22:0], miso};
      end
      sclk = 1'b1;
      step(half);
      sclk = 1'b0;
    end
    step(half);
    cs_n = 1'b1;
    mosi = ~mosi; // released line must not keep a stale level
    step(half);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_afe_control_and_sample_timing.sv ***
// self-checking bench for the control and sample timing block
`timescale 1ns/1ps
`default_nettype none
module tb_afe_control_and_sample_timing;
  localparam int FAULT_FLAG_REGISTER_N = 20;
  localparam int TICK   = aft_pkg::TICK_DIV;
  logic                        clk;
  logic                        reset;
  logic                        sclk;
  logic                        mosi;
  logic                        cs_n;
  logic                        miso;
  logic                        sample;
  logic                        fault_flag_register_active;
  logic                        fault_flag_register_done;
  logic                        timer_hold;
  logic [aft_pkg::COUNT_W-1:0] period_count;
  logic [23:0]                 rd;
  int                          errors;
  int                          checks;
  int                          n;
  int                          m;

  aft_control #(.FAULT_FLAG_REGISTER_CYCLES(FAULT_FLAG_REGISTER_N)) uut (
    .CLK          (clk),
    .RESET        (reset),
    .SCLK         (sclk),
    .MOSI         (mosi),
    .CS_N         (cs_n),
    .PERIOD_COUNT (period_count),
    .MISO         (miso),
    .SAMPLE_LED1  (sample),
    .FAULT_FLAG_REGISTER_ACTIVE  (fault_flag_register_active),
    .FAULT_FLAG_REGISTER_DONE    (fault_flag_register_done),
    .TIMER_HOLD   (timer_hold)
  );

  aft_spi_host host (
    .clk  (clk),
    .miso (miso),
    .sclk (sclk),
    .mosi (mosi),
    .cs_n (cs_n)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  // print counts and verdict, then stop
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    logic [23:0] unused;
    host.xfer(a, d, 6, unused);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp,
                        input int half);
    host.xfer(a, 24'h000000, half, rd);
    check(rd, exp);
  endtask
  // level of the watched output: 0 sample window, 1 diagnostics
  function automatic logic watched(input int sel);
    return (sel == 0) ? sample : fault_flag_register_active;
  endfunction
  // bounded wait for a level
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    int k;
    k = 0;
    while (watched(sel) !== lvl) begin
      @(posedge clk);
      #1;
      k++;
      if (k > lim) begin
        errors++;
        $display("ERROR at %0t: wait ran out", $time);
        report_and_stop();
      end
    end
  endtask
  // count cycles while the watched output keeps a level
  task automatic count_while(input int sel, input logic lvl, input int lim,
                             output int cnt);
    cnt = 0;
    while (watched(sel) === lvl && cnt <= lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  // length of the next whole segment at a level
  task automatic seg_len(input int sel, input logic lvl, input int lim,
                         output int cnt);
    wait_for(sel, ~lvl, lim);
    wait_for(sel, lvl, lim);
    count_while(sel, lvl, lim, cnt);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    reset = 1'b1;
    period_count = 16'h0020;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    @(posedge clk);
    #1;
    check({22'h0, timer_hold, fault_flag_register_active}, 24'h000000);
    // count writes land while readback is off, reads give zero
    wr(8'h01, 24'hab1234);
    rd_chk(8'h01, 24'h000000, 6);
    // a gated read frame is also a write of zero, so restore the count
    wr(8'h01, 24'hab1234);
    wr(8'h00, 24'h000001);
    rd_chk(8'h01, 24'h001234, 10);
    rd_chk(8'h00, 24'h000000, 6);
    rd_chk(8'h05, 24'h000000, 6);
    // readback on again: this count write must be refused
    wr(8'h00, 24'h000001);
    wr(8'h02, 24'h000055);
    rd_chk(8'h02, 24'h000000, 6);
    // program the window and read it back
    wr(8'h00, 24'h000000);
    wr(8'h01, 24'h000004);
    wr(8'h02, 24'h000006);
    wr(8'h03, 24'h000077);
    wr(8'h00, 24'h000001);
    rd_chk(8'h01, 24'h000004, 6);
    rd_chk(8'h02, 24'h000006, 6);
    // window of counts 4..6 inside a period of counts 0..32
    seg_len(0, 1'b1, 3000, n);
    count_while(0, 1'b0, 3000, m);
    check(24'(n), 24'(3 * TICK));
    check(24'(m), 24'(30 * TICK));
    // held counters keep the window shut
    wr(8'h00, 24'h000003);
    check({23'h0, timer_hold}, 24'h000001);
    m = 0;
    repeat (1700) begin
      @(posedge clk);
      #1;
      if (sample !== 1'b0) m++;
    end
    check(24'(m), 24'h000000);
    wr(8'h00, 24'h000001);
    check({23'h0, timer_hold}, 24'h000000);
    seg_len(0, 1'b1, 3000, n);
    check(24'(n), 24'(3 * TICK));
    // diagnostics twice: self-clear lets a second run start
    repeat (2) begin
      fork
        wr(8'h00, 24'h000005);
        seg_len(1, 1'b1, 600, n);
      join
      check(24'(n), 24'(FAULT_FLAG_REGISTER_N));
      check({23'h0, fault_flag_register_done}, 24'h000001);
      @(posedge clk);
      #1;
      check({23'h0, fault_flag_register_done}, 24'h000000);
    end
    // soft reset together with other bits clears everything
    wr(8'h00, 24'h00000b);
    check({23'h0, timer_hold}, 24'h000000);
    rd_chk(8'h01, 24'h000000, 6);
    wr(8'h00, 24'h000001);
    rd_chk(8'h01, 24'h000000, 6);
    rd_chk(8'h02, 24'h000000, 6);
    seg_len(0, 1'b1, 3000, n);
    count_while(0, 1'b0, 3000, m);
    check(24'(n), 24'(TICK));
    check(24'(m), 24'(32 * TICK));
    report_and_stop();
  end
endmodule
`default_nettype wire
